// *** hw/cij_regs.svh ***
/*
 * Encoding constants, field positions and fixed values of the compact
 * indirect jump unit.
 * Assumes a 32-bit instruction word and 32 general registers.
 */
`ifndef CIJ_REGS_SVH
`define CIJ_REGS_SVH

// ----------------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------------
`define CIJ_MAJOR_HI 31
`define CIJ_MAJOR_LO 26
`define CIJ_LINKF_HI 25
`define CIJ_LINKF_LO 21
`define CIJ_BASEF_HI 20
`define CIJ_BASEF_LO 16
`define CIJ_EXTF_HI 15
`define CIJ_EXTF_LO 6
`define CIJ_MINOR_HI 5
`define CIJ_MINOR_LO 0
`define CIJ_OFFS_HI 15
`define CIJ_OFFS_LO 0

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define CIJ_OP_POOL_ZERO 6'h00
`define CIJ_OP_GROUP_A 6'h28
`define CIJ_OP_GROUP_B 6'h20
`define CIJ_SUB_INDEXED 5'h00
`define CIJ_EXT_BARRIER_LINK 10'h07C
`define CIJ_MINOR_AXF 6'h3C
`define CIJ_EXEC_BARRIER_WORD 32'h0000_1800

// ----------------------------------------------------------------------
// Fixed values and reset values
// ----------------------------------------------------------------------
`define CIJ_LINK_DEFAULT 5'h1F
`define CIJ_ZERO_REG 5'h00
`define CIJ_PC_STEP 32'h0000_0004
`define CIJ_WORD_RST 32'h0000_0000

`endif

// *** hw/cij_pkg.sv ***
/*
 * Types shared by the compact indirect jump unit.
 * Assumes 32-bit addresses and 5-bit register indices.
 */
package cij_pkg;

    typedef enum logic [4:0] {
        KIND_NONE = 5'h01,
        KIND_BARRIER_JUMP_LINK = 5'h02,
        KIND_INDEXED_JUMP_LINK = 5'h04,
        KIND_INDEXED_JUMP = 5'h08,
        KIND_EXEC_BARRIER = 5'h10
    } cij_kind_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_HAZARD = 4'h4,
        ST_REDIRECT = 4'h8
    } cij_state_e;

    typedef struct packed {
        logic valid;
        logic [31:0] instr;
        logic [31:0] pc;
    } cij_issue_s;

    typedef struct packed {
        logic valid;
        logic [31:0] target;
    } cij_ret_s;

    typedef struct packed {
        logic we;
        logic [4:0] idx;
        logic [31:0] value;
    } cij_link_s;

    typedef struct packed {
        logic req;
        logic instrToo;
    } cij_hazard_s;

    typedef struct packed {
        logic valid;
        logic [31:0] target;
        logic isaSel;
        logic addrFault;
        logic squashNext;
    } cij_redirect_s;

endpackage : cij_pkg

// *** hw/cij_decode.sv ***
/*
 * Instruction classifier of the compact indirect jump unit.
 * Purely combinational; the caller registers its results.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cij_regs.svh"

module cij_decode (
    input wire logic [31:0] instr,
    output cij_pkg::cij_kind_e kind,
    output logic [4:0] baseIdx,
    output logic [4:0] linkIdx,
    output logic [15:0] offset
);

    logic [5:0] major;
    logic [4:0] sub;
    logic [9:0] ext;
    logic [5:0] minor;

    assign major = instr[`CIJ_MAJOR_HI:`CIJ_MAJOR_LO];
    assign sub = instr[`CIJ_LINKF_HI:`CIJ_LINKF_LO];
    assign ext = instr[`CIJ_EXTF_HI:`CIJ_EXTF_LO];
    assign minor = instr[`CIJ_MINOR_HI:`CIJ_MINOR_LO];
    assign baseIdx = instr[`CIJ_BASEF_HI:`CIJ_BASEF_LO];
    assign offset = instr[`CIJ_OFFS_HI:`CIJ_OFFS_LO];

    always_comb begin
        kind = cij_pkg::KIND_NONE;
        linkIdx = `CIJ_ZERO_REG;
        if (instr == `CIJ_EXEC_BARRIER_WORD) begin
            kind = cij_pkg::KIND_EXEC_BARRIER;
        end else if (major == `CIJ_OP_POOL_ZERO && ext == `CIJ_EXT_BARRIER_LINK
                     && minor == `CIJ_MINOR_AXF) begin
            kind = cij_pkg::KIND_BARRIER_JUMP_LINK;
            linkIdx = sub;
        end else if (major == `CIJ_OP_GROUP_A && sub == `CIJ_SUB_INDEXED) begin
            kind = cij_pkg::KIND_INDEXED_JUMP_LINK;
            linkIdx = `CIJ_LINK_DEFAULT;
        end else if (major == `CIJ_OP_GROUP_B && sub == `CIJ_SUB_INDEXED) begin
            kind = cij_pkg::KIND_INDEXED_JUMP;
        end
    end

endmodule : cij_decode

`default_nettype wire

// *** hw/cij_target.sv ***
/*
 * Jump target former: adds the unshifted offset, splits off the mode bit
 * and judges whether the later fetch of the target must fault.
 * Purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cij_regs.svh"

module cij_target #(
    parameter bit DUAL_SET = 1'b1
) (
    input wire logic [31:0] base,
    input wire logic [15:0] offset,
    input wire logic addOffset,
    output logic [31:0] target,
    output logic isaSel,
    output logic addrFault
);

    logic [31:0] sum;
    logic [31:0] addend;

    // Sign extended, not shifted: each offset bit meets the same base bit
    assign addend = addOffset ? {{16{offset[15]}}, offset} : `CIJ_WORD_RST;
    assign sum = base + addend;
    assign isaSel = sum[0];
    assign target = {sum[31:1], 1'b0};

    // Fault is only a mark carried with the target, raised at its fetch
    always_comb begin
        if (DUAL_SET) begin
            addrFault = !sum[0] && sum[1];
        end else begin
            addrFault = !sum[0];
        end
    end

endmodule : cij_target

`default_nettype wire

// *** hw/cij_unit.sv ***
/*
 * Compact indirect jump unit: executes the barrier jump and link (and its
 * no-link form), the indexed jump and link, the indexed jump, the
 * execution barrier and the exception return redirect.
 * Assumes a register file, hazard logic and fetch unit on mclk; the
 * register file answers rfReadIdx with rfReadData in the same cycle.
 * Timing: an issue taken at one edge reads its base register in the
 * next cycle; indexed jumps redirect fetch one cycle after that.
 * Barrier jumps and exception returns hold a full hazard request
 * until the hazard logic answers, and only then redirect fetch.
 * An exception return loads its redirect while the hazard request
 * stands, so the target never comes from a stale capture.
 * The execution barrier asks for execution hazards only and never
 * redirects. issueReady stays low until the work is accepted.
 * The fault mark only rides with the redirect; fetch raises it.
 */
// Operation
// - Barrier jumps clear all hazards before target fetch
// - Execution barrier clears execution hazards only
// - Barrier jump link writes PC+4 to link register
// - Barrier jump is link form with zero register
// - Decode indexed jump link from group A
// - Indexed link target: base plus unshifted sign-extended offset
// - Indexed jump link writes PC+4 to register 31
// - Decode indexed jump from group B
// - Indexed jump target: base plus unshifted offset
// - No delay slot: squash following instruction
// - Single set: mode bit zero faults at fetch
// - Dual set: load selector, clear bit, check alignment
// - Bit 1 set in word mode faults at fetch
// - Any instruction may follow a jump immediately
// - Jumps raise no exception at execution
// - Decode barrier jump link from pool zero
`timescale 1ns/1ps
`default_nettype none
`include "cij_regs.svh"

module cij_unit #(
    parameter bit DUAL_SET_PRESENT = 1'b1,
    parameter int REG_INDEX_W = 5
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire cij_pkg::cij_issue_s issue,
    output logic issueReady,
    input wire cij_pkg::cij_ret_s excReturn,
    output logic [REG_INDEX_W-1:0] rfReadIdx,
    input wire logic [31:0] rfReadData,
    output cij_pkg::cij_link_s linkWrite,
    output cij_pkg::cij_hazard_s hazardReq,
    input wire logic hazardDone,
    output cij_pkg::cij_redirect_s redirect,
    input wire logic redirectReady
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    cij_pkg::cij_state_e state_q;
    cij_pkg::cij_state_e state_d;
    cij_pkg::cij_kind_e decKind;
    cij_pkg::cij_kind_e kind_q;
    logic [4:0] decBase;
    logic [4:0] decLink;
    logic [15:0] decOffset;
    logic [4:0] linkIdx_q;
    logic [15:0] offset_q;
    logic [31:0] pc_q;
    logic [31:0] retTarget_q;
    logic isRet_q;
    logic [31:0] tgtBase;
    logic [31:0] tgtAddr;
    logic tgtIsa;
    logic tgtFault;
    logic issueReady_q;
    logic [REG_INDEX_W-1:0] rfReadIdx_q;
    cij_pkg::cij_link_s linkWrite_q;
    cij_pkg::cij_hazard_s hazardReq_q;
    cij_pkg::cij_redirect_s redirect_q;
    logic takeRet;
    logic takeIssue;
    logic needRedirect;
    logic addOffset;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic uses_offset(input cij_pkg::cij_kind_e k);
        return k == cij_pkg::KIND_INDEXED_JUMP_LINK || k == cij_pkg::KIND_INDEXED_JUMP;
    endfunction : uses_offset

    // ------------------------------------------------------------------
    // Decode and target forming
    // ------------------------------------------------------------------
    cij_decode u_decode (
        .instr(issue.instr),
        .kind(decKind),
        .baseIdx(decBase),
        .linkIdx(decLink),
        .offset(decOffset)
    );

    assign tgtBase = isRet_q ? retTarget_q : rfReadData;
    assign addOffset = uses_offset(kind_q);

    cij_target #(
        .DUAL_SET(DUAL_SET_PRESENT)
    ) u_target (
        .base(tgtBase),
        .offset(offset_q),
        .addOffset(addOffset),
        .target(tgtAddr),
        .isaSel(tgtIsa),
        .addrFault(tgtFault)
    );

    // Exception return wins over an issue offered in the same cycle
    assign takeRet = issueReady_q && excReturn.valid;
    assign takeIssue = issueReady_q && issue.valid && !excReturn.valid
                       && decKind != cij_pkg::KIND_NONE;
    assign needRedirect = kind_q != cij_pkg::KIND_EXEC_BARRIER;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            cij_pkg::ST_IDLE: begin
                if (takeRet) begin
                    state_d = cij_pkg::ST_HAZARD;
                end else if (takeIssue) begin
                    if (decKind == cij_pkg::KIND_EXEC_BARRIER) begin
                        state_d = cij_pkg::ST_HAZARD;
                    end else begin
                        state_d = cij_pkg::ST_READ;
                    end
                end
            end
            cij_pkg::ST_READ: begin
                if (kind_q == cij_pkg::KIND_BARRIER_JUMP_LINK) begin
                    state_d = cij_pkg::ST_HAZARD;
                end else begin
                    state_d = cij_pkg::ST_REDIRECT;
                end
            end
            cij_pkg::ST_HAZARD: begin
                if (hazardDone) begin
                    if (needRedirect) begin
                        state_d = cij_pkg::ST_REDIRECT;
                    end else begin
                        state_d = cij_pkg::ST_IDLE;
                    end
                end
            end
            cij_pkg::ST_REDIRECT: begin
                if (redirectReady) begin
                    state_d = cij_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = cij_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= cij_pkg::ST_IDLE;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Issue acceptance and captured instruction
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            issueReady_q <= 1'b1;
        end else if (clkEn) begin
            issueReady_q <= (state_d == cij_pkg::ST_IDLE);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            kind_q <= cij_pkg::KIND_NONE;
            linkIdx_q <= `CIJ_ZERO_REG;
            offset_q <= 16'h0000;
            pc_q <= `CIJ_WORD_RST;
            rfReadIdx_q <= '0;
        end else if (clkEn) begin
            if (takeRet) begin
                kind_q <= cij_pkg::KIND_NONE;
                linkIdx_q <= `CIJ_ZERO_REG;
                offset_q <= 16'h0000;
            end else if (takeIssue) begin
                kind_q <= decKind;
                linkIdx_q <= decLink;
                offset_q <= decOffset;
                pc_q <= issue.pc;
                rfReadIdx_q <= decBase[REG_INDEX_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Exception return capture
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            retTarget_q <= `CIJ_WORD_RST;
            isRet_q <= 1'b0;
        end else if (clkEn) begin
            if (takeRet) begin
                retTarget_q <= excReturn.target;
                isRet_q <= 1'b1;
            end else if (takeIssue) begin
                isRet_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Return link write
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            linkWrite_q <= '0;
        end else if (clkEn) begin
            linkWrite_q.we <= 1'b0;
            if (state_q == cij_pkg::ST_READ) begin
                // Base was read this cycle, so link == base is safe
                linkWrite_q.we <= (linkIdx_q != `CIJ_ZERO_REG);
                linkWrite_q.idx <= linkIdx_q;
                linkWrite_q.value <= pc_q + `CIJ_PC_STEP;
            end
        end
    end

    // ------------------------------------------------------------------
    // Hazard clearing request
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hazardReq_q <= '0;
        end else if (clkEn) begin
            if (state_d == cij_pkg::ST_HAZARD) begin
                hazardReq_q.req <= 1'b1;
                if (state_q != cij_pkg::ST_HAZARD) begin
                    hazardReq_q.instrToo <= takeRet
                        || state_q == cij_pkg::ST_READ;
                end
            end else begin
                hazardReq_q <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Fetch redirect
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            redirect_q <= '0;
        end else if (clkEn) begin
            if (state_q == cij_pkg::ST_READ
                || (state_q == cij_pkg::ST_HAZARD && isRet_q)) begin
                // Fault is only carried to fetch, never raised here
                redirect_q.target <= tgtAddr;
                redirect_q.isaSel <= DUAL_SET_PRESENT ? tgtIsa : 1'b1;
                redirect_q.addrFault <= tgtFault;
                redirect_q.squashNext <= 1'b1;
            end
            if (state_d == cij_pkg::ST_REDIRECT) begin
                redirect_q.valid <= 1'b1;
            end else begin
                redirect_q.valid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign issueReady = issueReady_q;
    assign rfReadIdx = rfReadIdx_q;
    assign linkWrite = linkWrite_q;
    assign hazardReq = hazardReq_q;
    assign redirect = redirect_q;

endmodule : cij_unit

`default_nettype wire

// *** test/cij_unit_properties.sv ***
/* Port checker for cij_unit.
   Assumes one clock, mclk, and async active-low resetn. */
`timescale 1ns/1ps
`default_nettype none
module cij_unit_properties #(
    parameter bit DUAL_SET_PRESENT = 1'b1,
    parameter int REG_INDEX_W = 5
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire cij_pkg::cij_issue_s issue,
    input wire logic issueReady,
    input wire cij_pkg::cij_ret_s excReturn,
    input wire logic [REG_INDEX_W-1:0] rfReadIdx,
    input wire logic [31:0] rfReadData,
    input wire cij_pkg::cij_link_s linkWrite,
    input wire cij_pkg::cij_hazard_s hazardReq,
    input wire logic hazardDone,
    input wire cij_pkg::cij_redirect_s redirect,
    input wire logic redirectReady
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic takeIdx;
    logic [4:0] baseField;
    logic [31:0] pcPlus;
    assign baseField = issue.instr[20:16];
    assign pcPlus = issue.pc + 32'h0000_0004;
    assign takeIdx = clkEn && issueReady && issue.valid && !excReturn.valid
        && issue.instr[25:21] == 5'h00
        && (issue.instr[31:26] == 6'h28 || issue.instr[31:26] == 6'h20);
    property p_idx_timing;
        takeIdx |=> rfReadIdx == $past(baseField) ##1 redirect.valid;
    endproperty
    a_idx_timing: assert property (p_idx_timing)
        else $error("indexed jump timing wrong");
    property p_idx_link;
        takeIdx && issue.instr[31:26] == 6'h28 |-> ##2 linkWrite.we
            && linkWrite.idx == 5'h1F && linkWrite.value == $past(pcPlus, 2);
    endproperty
    a_idx_link: assert property (p_idx_link)
        else $error("indexed link write wrong");
    property p_idx_nolink;
        takeIdx && issue.instr[31:26] == 6'h20 |-> ##1 !linkWrite.we ##1 !linkWrite.we;
    endproperty
    a_idx_nolink: assert property (p_idx_nolink)
        else $error("indexed jump wrote a register");
    property p_link_nonzero;
        linkWrite.we |-> linkWrite.idx != 5'h00;
    endproperty
    a_link_nonzero: assert property (p_link_nonzero)
        else $error("link write to register zero");
    property p_no_fetch_before_clear;
        hazardReq.req && hazardReq.instrToo |-> !redirect.valid;
    endproperty
    a_no_fetch_before_clear: assert property (p_no_fetch_before_clear)
        else $error("redirect before hazards cleared");
    property p_clear_then_fetch;
        clkEn && hazardReq.req && hazardReq.instrToo && hazardDone
            |=> redirect.valid && !hazardReq.req;
    endproperty
    a_clear_then_fetch: assert property (p_clear_then_fetch)
        else $error("no redirect after hazard clear");
    property p_exec_only;
        clkEn && hazardReq.req && !hazardReq.instrToo && hazardDone
            |=> issueReady && !redirect.valid;
    endproperty
    a_exec_only: assert property (p_exec_only)
        else $error("execution barrier misbehaved");
    property p_redirect_form;
        redirect.valid |-> !redirect.target[0] && redirect.squashNext;
    endproperty
    a_redirect_form: assert property (p_redirect_form)
        else $error("redirect bit 0 or squash wrong");
    property p_fault;
        redirect.valid |-> !DUAL_SET_PRESENT
            || redirect.addrFault == (!redirect.isaSel && redirect.target[1]);
    endproperty
    a_fault: assert property (p_fault)
        else $error("address fault flag wrong");
    property p_redirect_hold;
        clkEn && redirect.valid && !redirectReady |=> redirect.valid && $stable(redirect.target);
    endproperty
    a_redirect_hold: assert property (p_redirect_hold)
        else $error("redirect dropped early");
    property p_exc_return;
        clkEn && issueReady && excReturn.valid |=> hazardReq.req && hazardReq.instrToo;
    endproperty
    a_exc_return: assert property (p_exc_return)
        else $error("return did not request full clear");
endmodule : cij_unit_properties
bind cij_unit cij_unit_properties #(.DUAL_SET_PRESENT(DUAL_SET_PRESENT),
    .REG_INDEX_W(REG_INDEX_W)) cij_unit_properties_inst (.mclk(mclk), .resetn(resetn),
    .clkEn(clkEn), .issue(issue), .issueReady(issueReady), .excReturn(excReturn),
    .rfReadIdx(rfReadIdx), .rfReadData(rfReadData), .linkWrite(linkWrite),
    .hazardReq(hazardReq), .hazardDone(hazardDone), .redirect(redirect),
    .redirectReady(redirectReady));
`default_nettype wire

// *** test/cij_far_end.sv ***
/* Register file, hazard logic and fetch of the core around cij_unit.
   Assumes the bench loads regs directly; slow adds wait cycles. */
`timescale 1ns/1ps
`default_nettype none
module cij_far_end (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic [4:0] rfReadIdx,
    output logic [31:0] rfReadData,
    input wire cij_pkg::cij_hazard_s hazardReq,
    output logic hazardDone,
    input wire cij_pkg::cij_redirect_s redirect,
    output logic redirectReady
);
    logic [31:0] regs [32];
    logic [1:0] hzCnt;
    logic [1:0] rdCnt;
    assign rfReadData = (rfReadIdx == 5'h00) ? 32'h0000_0000 : regs[rfReadIdx];
    // Hazards cleared only when asked
    assign hazardDone = hazardReq.req && hzCnt == (slow ? 2'h3 : 2'h0);
    assign redirectReady = redirect.valid && rdCnt == (slow ? 2'h2 : 2'h0);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hzCnt <= 2'h0;
            rdCnt <= 2'h0;
        end else begin
            hzCnt <= (hazardReq.req && !hazardDone) ? hzCnt + 2'h1 : 2'h0;
            rdCnt <= (redirect.valid && !redirectReady) ? rdCnt + 2'h1 : 2'h0;
        end
    end
endmodule : cij_far_end
`default_nettype wire

// *** test/tb.sv ***
/* Self-checking bench for cij_unit with the core model.
   Assumes DUAL_SET_PRESENT of 1. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [31:0] instr; logic [31:0] pc; logic [31:0] tgt;
        logic isa; logic flt; logic lnk; logic [4:0] lidx; logic hz;
    } cij_row_s;
    logic mclk = 1'b0;
    logic resetn, clkEn, slow, redirectReady, hazardDone, issueReady;
    logic linkSeen, hazSeen, hzToo, redirSeen, gotIsa, gotFlt;
    logic [4:0] rfReadIdx, linkIdx;
    logic [31:0] rfReadData, linkVal, gotTgt;
    cij_pkg::cij_issue_s issue;
    cij_pkg::cij_ret_s excReturn;
    cij_pkg::cij_link_s linkWrite;
    cij_pkg::cij_hazard_s hazardReq;
    cij_pkg::cij_redirect_s redirect;
    cij_row_s rows [8];
    int failCount = 0;
    int numChecks = 0;
    always #20 mclk = ~mclk;
    cij_unit cij_unit_inst (.mclk(mclk), .resetn(resetn), .clkEn(clkEn), .issue(issue),
        .issueReady(issueReady), .excReturn(excReturn), .rfReadIdx(rfReadIdx),
        .rfReadData(rfReadData), .linkWrite(linkWrite), .hazardReq(hazardReq),
        .hazardDone(hazardDone), .redirect(redirect), .redirectReady(redirectReady));
    cij_far_end cij_far_end_inst (.mclk(mclk), .resetn(resetn), .slow(slow),
        .rfReadIdx(rfReadIdx), .rfReadData(rfReadData), .hazardReq(hazardReq),
        .hazardDone(hazardDone), .redirect(redirect), .redirectReady(redirectReady));
    always @(posedge mclk) begin
        if (linkWrite.we) begin
            linkSeen <= 1'b1;
            linkIdx <= linkWrite.idx;
            linkVal <= linkWrite.value;
        end
        if (hazardReq.req) begin
            hazSeen <= 1'b1;
            hzToo <= hazardReq.instrToo;
        end
        if (redirect.valid) redirSeen <= 1'b1;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task give_verdict;
        $display("checks=%0d mismatches=%0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task tick;
        @(posedge mclk);
        #1;
    endtask : tick
    task wait_for(input bit onRedirect);
        int n;
        n = 0;
        while (onRedirect ? !(redirect.valid === 1'b1 && redirectReady === 1'b1)
                          : issueReady !== 1'b1) begin
            tick;
            n++;
            if (n > 50) begin
                failCount++;
                $display("Wait limit reached t=%0t", $time);
                give_verdict;
            end
        end
        gotTgt = redirect.target;
        gotIsa = redirect.isaSel;
        gotFlt = redirect.addrFault;
    endtask : wait_for
    task issue_op(input logic [31:0] i, input logic [31:0] p, input bit withRet);
        wait_for(1'b0);
        {linkSeen, hazSeen, hzToo, redirSeen} = 4'h0;
        @(posedge mclk);
        issue <= '{1'b1, i, p};
        excReturn <= '{withRet, 32'h0000_4001};
        @(posedge mclk);
        issue.valid <= 1'b0;
        excReturn.valid <= 1'b0;
        #1;
    endtask : issue_op
    initial begin
        {resetn, slow, linkSeen, hazSeen, hzToo, redirSeen} = 6'h00;
        clkEn = 1'b1;
        issue = '0;
        excReturn = '0;
        cij_far_end_inst.regs[5] = 32'h1000_0000;
        cij_far_end_inst.regs[6] = 32'h2000_0000;
        cij_far_end_inst.regs[7] = 32'h0000_0100;
        cij_far_end_inst.regs[8] = 32'h0000_0203;
        // Barrier rows expect a hazard request as well as a redirect to the target
        rows = '{'{32'hA005_0001, 32'h0000_0400, 32'h1000_0000, 1, 0, 1, 5'h1F, 0},
                 '{32'hA006_FFFE, 32'h0000_0800, 32'h1FFF_FFFE, 0, 1, 1, 5'h1F, 0},
                 '{32'h8007_0004, 32'h0000_0C00, 32'h0000_0104, 0, 0, 0, 5'h00, 0},
                 '{32'h8007_8003, 32'h0000_0C04, 32'hFFFF_8102, 1, 0, 0, 5'h00, 0},
                 '{32'h8000_0011, 32'h0000_0C08, 32'h0000_0010, 1, 0, 0, 5'h00, 0},
                 '{32'h03E5_1F3C, 32'h0000_1000, 32'h1000_0000, 0, 0, 1, 5'h1F, 1},
                 '{32'h0006_1F3C, 32'h0000_1004, 32'h2000_0000, 0, 0, 0, 5'h00, 1},
                 '{32'h0068_1F3C, 32'h0000_1008, 32'h0000_0202, 1, 0, 1, 5'h03, 1}};
        @(posedge mclk);
        #1;
        chk({issueReady, redirect.valid, hazardReq.req, linkWrite.we}, 4'b1000);
        @(posedge mclk);
        resetn <= 1'b1;
        for (int pass = 0; pass < 2; pass++) begin
            slow = pass[0];
            for (int k = 0; k < 8; k++) begin
                issue_op(rows[k].instr, rows[k].pc, 1'b0);
                wait_for(1'b1);
                tick;
                chk(gotTgt, rows[k].tgt);
                chk({gotIsa, gotFlt}, {rows[k].isa, rows[k].flt});
                chk({hazSeen, linkSeen}, {rows[k].hz, rows[k].lnk});
                if (rows[k].lnk) begin
                    chk(linkVal, rows[k].pc + 32'h0000_0004);
                    chk(linkIdx, rows[k].lidx);
                end
                $display("row %0d pass %0d done", k, pass);
            end
        end
        issue_op(32'h0000_1800, 32'h0000_0000, 1'b0);
        wait_for(1'b0);
        chk({hazSeen, hzToo, redirSeen}, 3'b100);
        $display("execution barrier test done");
        issue_op(rows[0].instr, 32'h0000_0000, 1'b1);
        wait_for(1'b1);
        tick;
        chk({gotTgt[15:0], gotIsa}, {16'h4000, 1'b1});
        chk({hazSeen, hzToo, linkSeen}, 3'b110);
        $display("exception return test done");
        issue_op(32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
        @(posedge mclk);
        clkEn <= 1'b0;
        issue <= '{1'b1, rows[2].instr, 32'h0000_0000};
        repeat (3) @(posedge mclk);
        issue.valid <= 1'b0;
        @(posedge mclk);
        clkEn <= 1'b1;
        repeat (2) tick;
        chk({issueReady, redirSeen, hazSeen, linkSeen}, 4'b1000);
        $display("ignored issue test done");
        issue_op(rows[5].instr, rows[5].pc, 1'b0);
        @(posedge mclk);
        resetn <= 1'b0;
        tick;
        chk({issueReady, redirect.valid, hazardReq.req, linkWrite.we}, 4'b1000);
        @(posedge mclk);
        resetn <= 1'b1;
        issue_op(rows[3].instr, rows[3].pc, 1'b0);
        wait_for(1'b1);
        chk(gotTgt, rows[3].tgt);
        $display("mid-run reset test done");
        tick;
        give_verdict;
    end
endmodule : tb
`default_nettype wire
